// file: verilog/rmoc_top.sv
`timescale 1ns/1ps
// What this block does
// - options are chosen at reset by sampling levels on interrupt pins
// - a tri-state option floats the device for board testing
// - a byte-order option picks big or little endian
// - a refill option picks one-word or four-word data cache refill
// - enhanced variant lets software rewrite refill size; reset value first
// - coherent DMA option enables the enhanced coherency interface
// - 1x clock option says input clock equals core frequency
// - half-frequency option runs the external bus at half core rate
// - read then write may turn the bus in 15 ns at 100 MHz
// - enhanced variant has a config bit lengthening bus turnaround
// - enhanced variant feeds FP exceptions onto one interrupt, pin ignored
// - enhanced variant takes coprocessor condition internally, ignores pin
// - slow-bus bit at 1 adds extra turnaround time
// - refill bit at 1 selects a four-word refill
module rmoc_top
	import rmoc_pkg::*;
#(
	parameter bit P_ENHANCED = 1'b1
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [NPINS-1:0] i_int_pin,
	input wire logic i_coproc_one_condition_input,
	input wire logic i_fp_exception,
	input wire logic i_fp_compare_result,
	input wire logic i_bus_read_end,
	input wire logic i_bus_write_req,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [NPINS-1:0] o_core_int,
	output logic o_cp1_cond,
	output logic o_bus_write_grant,
	output logic o_bus_float,
	output logic o_byte_order_select,
	output logic o_data_refill_size_bit,
	output logic o_coherent_dma_en,
	output logic o_clock_1x,
	output logic o_half_bus,
	output logic o_slow_bus
);
	logic [NPINS-1:0] levels;
	logic refill_q;
	logic slow_q;
	logic lock_q;
	logic [2:0] fpidx_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [NPINS-1:0] core_int_q;
	logic [NPINS-1:0] core_int_d;
	logic cp1_q;
	logic [TURN_W-1:0] turn_q;
	logic req;
	logic cfg_wr;

	// reset-time capture and decode of the mode vector
	rmoc_capture #(
		.P_ENHANCED(P_ENHANCED)
	) u_capture (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_int_pin(i_int_pin),
		.o_levels(levels),
		.o_bus_float(o_bus_float),
		.o_byte_order_select(o_byte_order_select),
		.o_coherent_dma_en(o_coherent_dma_en),
		.o_clock_1x(o_clock_1x),
		.o_half_bus(o_half_bus)
	);

	// builds the config word as software sees it
	function automatic logic [31:0] cfg_word(input logic refill,
		input logic slow, input logic [2:0] fpidx, input logic lock);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[CFG_REFILL] = refill;
		w[CFG_SLOW] = slow;
		w[CFG_FPIDX_LO +: 3] = fpidx;
		w[CFG_LOCK] = lock;
		return w;
	endfunction

	// one wait state on every access keeps the decode off the bus path
	assign req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_q;
	assign cfg_wr = i_avs_write & ack_q & (i_avs_address == REG_CONFIG)
		& i_avs_byteenable[0] & P_ENHANCED & ~lock_q;

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// read decode; base variant has no config register and reads zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (i_avs_address)
			REG_CONFIG: begin
				if (P_ENHANCED) begin
					rdata_d = cfg_word(refill_q, slow_q, fpidx_q, lock_q);
				end
			end
			REG_MODE: begin
				rdata_d[NPINS-1:0] = levels;
				rdata_d[MODE_ENH_BIT] = P_ENHANCED;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// read data is loaded in the wait cycle so it stands at the answer
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (i_avs_read & ~ack_q) begin
			rdata_q <= rdata_d;
		end
	end
	assign o_avs_readdata = rdata_q;

	// refill size starts from the strap; software may change it in the enhanced variant only
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			refill_q <= ~i_int_pin[PIN_REFILL];
		end else if (cfg_wr) begin
			refill_q <= i_avs_writedata[CFG_REFILL];
		end
	end
	assign o_data_refill_size_bit = refill_q;

	// remaining config fields; lock stops all later writes
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			slow_q <= CFG_SLOW_RST;
			fpidx_q <= CFG_FPIDX_RST;
			lock_q <= CFG_LOCK_RST;
		end else if (cfg_wr) begin
			slow_q <= i_avs_writedata[CFG_SLOW];
			fpidx_q <= i_avs_writedata[CFG_FPIDX_LO +: 3];
			lock_q <= i_avs_writedata[CFG_LOCK];
		end
	end
	assign o_slow_bus = slow_q;

	// interrupts to the core: pins are active low, FP line is internal
	always_comb begin
		core_int_d = ~i_int_pin;
		if (P_ENHANCED && fpidx_q < 3'(NPINS)) begin
			core_int_d[fpidx_q] = i_fp_exception;
		end
	end

	// held clear in reset while the pins carry the mode vector
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			core_int_q <= '0;
		end else begin
			core_int_q <= core_int_d;
		end
	end
	assign o_core_int = core_int_q;

	// coprocessor condition source
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			cp1_q <= 1'b0;
		end else if (P_ENHANCED) begin
			cp1_q <= i_fp_compare_result;
		end else begin
			cp1_q <= i_coproc_one_condition_input;
		end
	end
	assign o_cp1_cond = cp1_q;

	// turnaround guard: after a read the write waits out the bus float
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			turn_q <= '0;
		end else if (i_bus_read_end) begin
			if (slow_q) begin
				turn_q <= TURN_W'(SLOW_CYC);
			end else begin
				turn_q <= TURN_W'(TURN_CYC);
			end
		end else if (turn_q != '0) begin
			turn_q <= turn_q - 4'h1;
		end
	end
	assign o_bus_write_grant = i_bus_write_req & (turn_q == '0) &
		~i_bus_read_end;

	// checks beside the logic
	sequence fast_turn_s;
		i_bus_read_end && !slow_q;
	endsequence
	sequence slow_turn_s;
		i_bus_read_end && slow_q;
	endsequence
	sequence access_s;
		req && !ack_q;
	endsequence

	mode_hold_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		$past(i_resetn) |-> $stable(levels))
		else $error("mode levels changed outside reset");

	refill_strap_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		$rose(i_resetn) |-> refill_q == ~levels[PIN_REFILL])
		else $error("refill size not taken from strap");

	cfg_write_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		cfg_wr |=> refill_q == $past(i_avs_writedata[CFG_REFILL]))
		else $error("config write did not set refill size");

	lock_hold_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(lock_q && i_avs_write) |=> $stable(slow_q) && $stable(refill_q))
		else $error("locked config changed");

	fp_route_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(P_ENHANCED && fpidx_q == 3'h3 && $stable(fpidx_q)) |=>
		o_core_int[3] == $past(i_fp_exception))
		else $error("fp exception not routed to interrupt");

	cp1_src_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		P_ENHANCED |=> o_cp1_cond == $past(i_fp_compare_result))
		else $error("coprocessor condition taken from pin");

	turn_fast_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		fast_turn_s |-> !o_bus_write_grant ##1 (!o_bus_write_grant)[*2])
		else $error("write granted inside fast turnaround");

	turn_slow_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		slow_turn_s |-> !o_bus_write_grant ##1 (!o_bus_write_grant)[*8])
		else $error("write granted inside slow turnaround");

	int_clear_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		$rose(i_resetn) |-> o_core_int == '0)
		else $error("interrupts not clear after reset");

	bus_wait_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		access_s |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("bus answer not after one wait state");

	float_opt_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		o_bus_float == ~levels[PIN_TRISTATE] &&
		o_byte_order_select == ~levels[PIN_BYTE_ORDER])
		else $error("tri-state or byte order decode wrong");

	enh_opt_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		!P_ENHANCED |-> !o_coherent_dma_en && !o_clock_1x &&
		!o_half_bus)
		else $error("enhanced option active in base variant");

	int_pin_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(fpidx_q != 3'h0 || !P_ENHANCED) |=>
		o_core_int[0] == !$past(i_int_pin[0]))
		else $error("interrupt pin 0 not passed to core");

	cp1_pin_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		!P_ENHANCED |=> o_cp1_cond == $past(i_coproc_one_condition_input))
		else $error("base variant ignored the condition pin");

	fast_release_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		fast_turn_s ##1 (!i_bus_read_end)[*3] |->
		o_bus_write_grant == i_bus_write_req)
		else $error("write not granted after fast turnaround");

	slow_release_a: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		slow_turn_s ##1 (!i_bus_read_end)[*8] ##1 !i_bus_read_end |->
		o_bus_write_grant == i_bus_write_req)
		else $error("write not granted after slow turnaround");
endmodule

// file: verilog/rmoc_pkg.sv
package rmoc_pkg;
	// clock and bus turnaround timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TURN_NS = 15;
	localparam int SLOW_EXTRA_NS = 60;
	localparam int TURN_CYC = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_CYC = (TURN_NS + SLOW_EXTRA_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int TURN_W = 4;

	// register byte offsets
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_MODE = 4'h4;

	// config register fields
	localparam int CFG_REFILL = 0;
	localparam int CFG_SLOW = 1;
	localparam int CFG_FPIDX_LO = 2;
	localparam int CFG_LOCK = 5;
	localparam logic [2:0] CFG_FPIDX_RST = 3'h3;
	localparam logic CFG_SLOW_RST = 1'b0;
	localparam logic CFG_LOCK_RST = 1'b0;

	// mode register fields
	localparam int MODE_ENH_BIT = 8;

	// mode vector pin positions; a low level at reset selects the option
	localparam int PIN_BYTE_ORDER = 0;
	localparam int PIN_REFILL = 1;
	localparam int PIN_TRISTATE = 2;
	localparam int PIN_COH_DMA = 3;
	localparam int PIN_CLK_1X = 4;
	localparam int PIN_HALF_BUS = 5;
	localparam int NPINS = 6;
	localparam logic [5:0] PINS_IDLE = 6'h3F;
endpackage

// file: verilog/rmoc_capture.sv
`timescale 1ns/1ps
module rmoc_capture
	import rmoc_pkg::*;
#(
	parameter bit P_ENHANCED = 1'b1
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [NPINS-1:0] i_int_pin,
	output logic [NPINS-1:0] o_levels,
	output logic o_bus_float,
	output logic o_byte_order_select,
	output logic o_coherent_dma_en,
	output logic o_clock_1x,
	output logic o_half_bus
);
	logic [NPINS-1:0] levels_q;

	// holding flops follow the pins during reset, frozen at release
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			levels_q <= i_int_pin;
		end
	end

	assign o_levels = levels_q;
	// base-variant boards tie the upper vectors high, so gating is harmless
	assign o_bus_float = ~levels_q[PIN_TRISTATE];
	assign o_byte_order_select = ~levels_q[PIN_BYTE_ORDER];
	assign o_coherent_dma_en = P_ENHANCED & ~levels_q[PIN_COH_DMA];
	assign o_clock_1x = P_ENHANCED & ~levels_q[PIN_CLK_1X];
	assign o_half_bus = P_ENHANCED & ~levels_q[PIN_HALF_BUS];
endmodule

// file: bench/rmoc_board.sv
`timescale 1ns/1ps
module rmoc_board #(
	parameter bit P_BASE = 1'b0
) (
	input wire logic i_resetn,
	input wire logic [5:0] i_strap,
	input wire logic [5:0] i_irq_n,
	input wire logic i_cp,
	output logic [5:0] o_int_pin,
	output logic o_cp_pin
);
	// straps only while reset is low; a base board ties 5:3 high in reset, only 3 after
	assign o_int_pin = !i_resetn ?
		(i_strap | (P_BASE ? 6'h38 : 6'h00)) :
		(i_irq_n | (P_BASE ? 6'h08 : 6'h00));
	// pull-up on a base board, so the pin never reads low there
	assign o_cp_pin = P_BASE ? 1'b1 : i_cp;
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rd_end = 1'b0;
	logic wreq = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic exc = 1'b0;
	logic cmp = 1'b0;
	logic cp = 1'b1;
	logic [3:0] adr = 4'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] wd = 32'h0;
	logic [31:0] q;
	logic [5:0] strap = 6'h2A;
	logic [5:0] irq_n = 6'h3F;
	logic [5:0] pins;
	logic [5:0] cint;
	logic [5:0] pins_b;
	logic [5:0] cint_b;
	logic [31:0] rdata;
	wire [4:0] opt;
	wire [4:0] opt_b;
	logic wait_r, cp1, grant, rfl, slow, cpin;
	logic cp1_b, rfl_b, slow_b, cpin_b;
	int fail_count = 0;
	int check_count = 0;

	// free-running 100 MHz clock
	always #5 clk = ~clk;

	rmoc_board u_board (.i_resetn(rstn), .i_strap(strap), .i_irq_n(irq_n),
		.i_cp(cp), .o_int_pin(pins), .o_cp_pin(cpin));

	rmoc_top u_dut (.i_mclk(clk), .i_resetn(rstn), .i_int_pin(pins),
		.i_coproc_one_condition_input(cpin), .i_fp_exception(exc),
		.i_fp_compare_result(cmp), .i_bus_read_end(rd_end),
		.i_bus_write_req(wreq), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
		.o_core_int(cint), .o_cp1_cond(cp1), .o_bus_write_grant(grant),
		.o_bus_float(opt[4]), .o_byte_order_select(opt[3]),
		.o_data_refill_size_bit(rfl), .o_coherent_dma_en(opt[2]),
		.o_clock_1x(opt[1]), .o_half_bus(opt[0]), .o_slow_bus(slow));

	// base-variant board and part on the same straps and bus
	rmoc_board #(.P_BASE(1'b1)) u_board_b (.i_resetn(rstn), .i_strap(strap),
		.i_irq_n(irq_n), .i_cp(cp), .o_int_pin(pins_b), .o_cp_pin(cpin_b));

	rmoc_top #(.P_ENHANCED(1'b0)) u_dut_b (.i_mclk(clk), .i_resetn(rstn),
		.i_int_pin(pins_b), .i_coproc_one_condition_input(cpin_b),
		.i_fp_exception(exc), .i_fp_compare_result(cmp),
		.i_bus_read_end(rd_end), .i_bus_write_req(wreq),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(),
		.o_avs_waitrequest(), .o_core_int(cint_b), .o_cp1_cond(cp1_b),
		.o_bus_write_grant(), .o_bus_float(opt_b[4]),
		.o_byte_order_select(opt_b[3]), .o_data_refill_size_bit(rfl_b),
		.o_coherent_dma_en(opt_b[2]), .o_clock_1x(opt_b[1]),
		.o_half_bus(opt_b[0]), .o_slow_bus(slow_b));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one avalon access; held until waitrequest is seen low at an edge
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		// no cycle limit here: only the watchdog ends a hung access
		do begin
			@(posedge clk);
		end while (wait_r !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task rchk(input logic [3:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	// grant must stay low for the end cycle plus n more
	task turn(input int n);
		@(posedge clk);
		rd_end <= 1'b1;
		repeat (n + 1) begin
			#1 chk(32'(grant), 32'h0);
			@(posedge clk);
			rd_end <= 1'b0;
		end
		#1 chk(32'(grant), 32'h1);
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// straps 2A then 15 after a second reset, so each option shows both ways
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		strap <= 6'h15;
		irq_n <= 6'h36;
		@(posedge clk);
		#1 chk(32'(opt), 32'h1A);
		chk(32'(opt_b), 32'h18);
		chk(32'({rfl, rfl_b}), 32'h0);
		@(posedge clk);
		exc <= 1'b1;
		cmp <= 1'b1;
		cp <= 1'b0;
		#1 chk(32'(cint), 32'h01);
		chk(32'(cint_b), 32'h01);
		chk(32'({cp1, cp1_b}), 32'h1);
		@(posedge clk);
		@(posedge clk);
		#1 chk(32'(cint), 32'h09);
		chk(32'(cint_b), 32'h01);
		chk(32'({cp1, cp1_b}), 32'h3);
		chk(32'(opt), 32'h1A);
		rchk(4'h4, 32'h12A);
		rchk(4'h0, 32'h0C);
		be <= 4'hE;
		acc(1'b1, 4'h0, 32'h3);
		be <= 4'hF;
		rchk(4'h0, 32'h0C);
		acc(1'b1, 4'h4, 32'h0);
		rchk(4'h4, 32'h12A);
		rchk(4'h8, 32'h0);
		acc(1'b1, 4'h0, 32'hF);
		#1 chk(32'({rfl, slow}), 32'h3);
		chk(32'({rfl_b, slow_b}), 32'h0);
		turn(8);
		acc(1'b1, 4'h0, 32'h2C);
		#1 chk(32'({rfl, slow}), 32'h0);
		turn(2);
		acc(1'b1, 4'h0, 32'hF);
		rchk(4'h0, 32'h2C);
		// mid-run reset with straps 15: new options taken, lock cleared
		@(posedge clk);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1 chk(32'(opt), 32'h05);
		chk(32'(opt_b), 32'h00);
		chk(32'({rfl, rfl_b}), 32'h3);
		rchk(4'h4, 32'h115);
		rchk(4'h0, 32'h0D);
		acc(1'b1, 4'h0, 32'hE);
		#1 chk(32'({rfl, slow}), 32'h1);
		chk(32'({rfl_b, slow_b}), 32'h2);
		summarize;
	end

	// whole run needs well under 2000 cycles
	initial begin
		#50000;
		fail_count++;
		summarize;
	end
endmodule
